// ===== hdl/sac_pkg.sv
package sac_pkg;
	localparam int ADDR_W = 5;
	localparam int RES_W = 10;
	localparam int NUM_CHAN = 7;
	localparam int NUM_REGS = 7;

	// Byte offsets of the registers.
	localparam logic [ADDR_W-1:0] OFF_CTRL_FIRST = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL_SECOND = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_RES_LOW = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h18;

	// Positions in the one-hot register select.
	localparam int SEL_CTRL_FIRST = 0;
	localparam int SEL_CTRL_SECOND = 1;
	localparam int SEL_RES_HIGH = 2;
	localparam int SEL_RES_LOW = 3;
	localparam int SEL_IRQ_STATUS = 4;
	localparam int SEL_IRQ_CLEAR = 5;
	localparam int SEL_IRQ_ENABLE = 6;

	// Field positions.
	localparam int F_ENABLE = 0;
	localparam int F_GO = 1;
	localparam int F_CHS_LO = 2;
	localparam int F_CHS_HI = 6;
	localparam int F_PREF_LO = 0;
	localparam int F_PREF_HI = 1;
	localparam int F_CKS_LO = 4;
	localparam int F_CKS_HI = 6;
	localparam int F_JUSTIFY = 7;
	localparam int F_DONE = 0;

	// Values after reset.
	localparam logic [4:0] RST_CHS = 5'h00;
	localparam logic [2:0] RST_CKS = 3'h0;
	localparam logic [1:0] RST_PREF = 2'h0;
	localparam logic [7:0] RST_RESULT = 8'h00;

	// Channel codes and clock codes.
	localparam logic [4:0] CHS_PIN_LAST = 5'h03;
	localparam logic [4:0] CHS_TEMP = 5'h1D;
	localparam logic [4:0] CHS_DAC = 5'h1E;
	localparam logic [4:0] CHS_REFBUF = 5'h1F;
	localparam logic [1:0] CKS_RC_LOW = 2'h3;

	// Sequencing counts: steps in half periods of the conversion clock, the RC start wait in system cycles.
	localparam logic [4:0] STEP_FIRST_BIT = 5'h02;
	localparam logic [4:0] STEP_LAST = 5'h16;
	localparam logic [3:0] RC_START_WAIT = 4'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sac_state_t;

	function automatic logic [NUM_REGS-1:0] sac_decode(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_CTRL_FIRST: return 7'h01;
			OFF_CTRL_SECOND: return 7'h02;
			OFF_RES_HIGH: return 7'h04;
			OFF_RES_LOW: return 7'h08;
			OFF_IRQ_STATUS: return 7'h10;
			OFF_IRQ_CLEAR: return 7'h20;
			OFF_IRQ_ENABLE: return 7'h40;
			default: return 7'h00;
		endcase
	endfunction : sac_decode

	// Half period of the divided clock in system cycles; zero selects the RC source.
	function automatic logic [5:0] sac_half_period(input logic [2:0] cks);
		case (cks)
			3'h0: return 6'h01;
			3'h4: return 6'h02;
			3'h1: return 6'h04;
			3'h5: return 6'h08;
			3'h2: return 6'h10;
			3'h6: return 6'h20;
			default: return 6'h00;
		endcase
	endfunction : sac_half_period

	function automatic logic [NUM_CHAN-1:0] sac_chan_onehot(input logic [4:0] channel_select_field);
		logic [NUM_CHAN-1:0] v;
		v = '0;
		if (channel_select_field <= CHS_PIN_LAST) begin
			v[channel_select_field[1:0]] = 1'b1;
		end else if (channel_select_field == CHS_TEMP) begin
			v[4] = 1'b1;
		end else if (channel_select_field == CHS_DAC) begin
			v[5] = 1'b1;
		end else if (channel_select_field == CHS_REFBUF) begin
			v[6] = 1'b1;
		end
		return v;
	endfunction : sac_chan_onehot

	// Returns the high byte above the low byte.
	function automatic logic [15:0] sac_format(input logic [RES_W-1:0] r, input logic right);
		if (right) begin
			return {6'h00, r};
		end
		return {r[9:2], r[1:0], 6'h00};
	endfunction : sac_format
endpackage : sac_pkg

// ===== hdl/sac_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module sac_clkgen
	import sac_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic run,
	input wire logic [2:0] cks,
	// Dedicated RC oscillator, asynchronous to aclk.
	input wire logic rc_osc,
	// One pulse per half period of the conversion clock.
	output logic half_tick
);
	logic [2:0] rc_sync_r;
	logic rc_lvl_r;
	logic [5:0] cnt_r;
	logic [5:0] half_len;
	logic rc_edge;

	assign half_len = sac_half_period(cks);
	assign rc_edge = (rc_sync_r[1] == rc_sync_r[2]) && (rc_sync_r[2] != rc_lvl_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_sync_r <= 3'h0;
		end else begin
			rc_sync_r <= {rc_sync_r[1:0], rc_osc};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_lvl_r <= 1'b0;
		end else if (rc_sync_r[1] == rc_sync_r[2]) begin
			rc_lvl_r <= rc_sync_r[2];
		end
	end

	// The divided clock counts aclk cycles, so it scales with any change of aclk.
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= 6'h00;
			half_tick <= 1'b0;
		end else if (half_len == 6'h00) begin
			cnt_r <= 6'h00;
			half_tick <= rc_edge;
		end else if (cnt_r >= half_len - 6'h01) begin
			cnt_r <= 6'h00;
			half_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 6'h01;
			half_tick <= 1'b0;
		end
	end
endmodule : sac_clkgen
`default_nettype wire

// ===== hdl/sac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Ten-bit successive approximation result stored in high and low result registers.
// - Seven sources: four pins, temperature sensor, DAC output, reference buffer.
// - Channel field of first control register picks the one source for sampling.
// - Positive reference field picks external reference pin or supply rail.
// - Clock field maps codes to system clock divide by 2 to 64 or RC.
// - A conversion lasts eleven and a half conversion clock periods.
// - Divided clocks follow the system clock; only RC is independent.
// - Completion flag is set at every completed conversion, interrupt enable or not; an abort leaves it clear.
// - Completion flag stays set until software clears it.
// - Flag and enable both set raise interrupt, which also wakes from sleep.
// - Conversions continue in sleep only with the RC clock selected.
// - Justify bit picks left or right placement of the result.
// - Completion clears go, sets the flag and loads both result registers.
// - Converter runs only when enabled; writing one to go starts it.
// - Right justify zeroes six upper high bits; left zeroes six lower low bits.
// - Codes 0 to 3 pins, 1D temperature, 1E DAC, 1F buffer; others nothing.
module sac_top
	import sac_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end.
	input wire logic cmp_in,
	input wire logic rc_osc_in,
	output logic [NUM_CHAN-1:0] chan_connect,
	output logic sample_hold,
	output logic [RES_W-1:0] dac_code,
	output logic [1:0] positive_reference_select,
	output logic converter_power,
	// System.
	input wire logic sleep_in,
	output logic irq,
	output logic wake_req
);
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] bresp_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [31:0] wdata_r;
	logic [31:0] rd_word;
	logic wstrb0_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [NUM_REGS-1:0] wsel;
	logic [NUM_REGS-1:0] rsel;
	logic wr_do;
	logic wr_en;
	logic enable_r;
	logic [4:0] chs_r;
	logic justify_r;
	logic [2:0] cks_r;
	logic [1:0] pref_r;
	logic flag_r;
	logic irq_en_r;
	logic irq_r;
	logic wake_r;
	logic power_r;
	logic hold_r;
	logic [NUM_CHAN-1:0] chan_r;
	sac_state_t state_r;
	logic [3:0] wait_r;
	logic [4:0] step_r;
	logic [RES_W-1:0] sar_r;
	logic [RES_W-1:0] decided_r;
	logic [RES_W-1:0] final_code;
	logic [3:0] bit_r;
	logic last_bit_r;
	logic [7:0] res_high_r;
	logic [7:0] res_low_r;
	logic [2:0] cmp_sync_r;
	logic cmp_r;
	logic half_tick;
	logic busy;
	logic conv;
	logic rc_sel;
	logic start;
	logic abort;
	logic finish;
	logic load;
	logic flag_clr;
	logic [5:0] ht_cnt_r;

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign chan_connect = chan_r;
	assign sample_hold = hold_r;
	assign dac_code = sar_r;
	assign positive_reference_select = pref_r;
	assign converter_power = power_r;
	assign irq = irq_r;
	assign wake_req = wake_r;

	// A write executes once address and data are both held and no response is pending.
	assign wr_do = !awready_r && !wready_r && !bvalid_r;
	assign wsel = sac_decode(awaddr_r);
	assign rsel = sac_decode(s_axi_araddr);
	assign wr_en = wr_do && wstrb0_r;

	assign busy = (state_r != ST_IDLE);
	assign conv = (state_r == ST_CONV);
	assign rc_sel = (cks_r[1:0] == CKS_RC_LOW);
	assign start = wr_en && wsel[SEL_CTRL_FIRST] && wdata_r[F_GO] && wdata_r[F_ENABLE] &&
		enable_r && !busy;
	assign abort = busy && ((wr_en && wsel[SEL_CTRL_FIRST] &&
		!(wdata_r[F_GO] && wdata_r[F_ENABLE])) || (sleep_in && !rc_sel));
	assign finish = conv && half_tick && (step_r == STEP_LAST) && !abort;
	assign load = finish || abort;
	assign flag_clr = wr_en && wsel[SEL_IRQ_CLEAR] && wdata_r[F_DONE];
	// Undecided bits of a cut-short conversion repeat the last decided bit.
	assign final_code = (sar_r & decided_r) | ({RES_W{last_bit_r}} & ~decided_r);

	sac_clkgen u_clkgen (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(conv),
		.cks(cks_r),
		.rc_osc(rc_osc_in),
		.half_tick(half_tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb0_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awready_r <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				wready_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				awready_r <= 1'b1;
				wready_r <= 1'b1;
				bvalid_r <= 1'b1;
				bresp_r <= (wsel != '0) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (rsel[SEL_CTRL_FIRST]) begin
			rd_word[7:0] = {1'b0, chs_r, busy, enable_r};
		end
		if (rsel[SEL_CTRL_SECOND]) begin
			rd_word[7:0] = {justify_r, cks_r, 2'h0, pref_r};
		end
		if (rsel[SEL_RES_HIGH]) begin
			rd_word[7:0] = res_high_r;
		end
		if (rsel[SEL_RES_LOW]) begin
			rd_word[7:0] = res_low_r;
		end
		if (rsel[SEL_IRQ_STATUS]) begin
			rd_word[F_DONE] = flag_r;
		end
		if (rsel[SEL_IRQ_ENABLE]) begin
			rd_word[F_DONE] = irq_en_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= (rsel != '0) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_r <= 1'b0;
			chs_r <= RST_CHS;
		end else if (wr_en && wsel[SEL_CTRL_FIRST]) begin
			enable_r <= wdata_r[F_ENABLE];
			chs_r <= wdata_r[F_CHS_HI:F_CHS_LO];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			justify_r <= 1'b0;
			cks_r <= RST_CKS;
			pref_r <= RST_PREF;
		end else if (wr_en && wsel[SEL_CTRL_SECOND]) begin
			justify_r <= wdata_r[F_JUSTIFY];
			cks_r <= wdata_r[F_CKS_HI:F_CKS_LO];
			pref_r <= wdata_r[F_PREF_HI:F_PREF_LO];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_r <= 1'b0;
		end else if (wr_en && wsel[SEL_IRQ_ENABLE]) begin
			irq_en_r <= wdata_r[F_DONE];
		end
	end

	// A completion in the cycle of a clear wins, so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= finish | (flag_r & ~flag_clr);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			irq_r <= flag_r && irq_en_r;
			wake_r <= sleep_in && flag_r && irq_en_r;
		end
	end

	// In sleep the analog part stays powered only for an RC conversion, or to idle
	// with the RC clock selected and interrupts enabled; the enable bit itself is left untouched.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_r <= 1'b0;
		end else begin
			power_r <= enable_r && !(sleep_in && (!rc_sel || (!busy && !irq_en_r)));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_r <= '0;
		end else begin
			chan_r <= enable_r ? sac_chan_onehot(chs_r) : '0;
		end
	end

	// The comparator settles asynchronously, so it is filtered before use. This costs
	// four cycles, which is why the three fastest divider settings give unreliable bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_sync_r <= 3'h0;
		end else begin
			cmp_sync_r <= {cmp_sync_r[1:0], cmp_in};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_r <= 1'b0;
		end else if (cmp_sync_r[1] == cmp_sync_r[2]) begin
			cmp_r <= cmp_sync_r[2];
		end
	end

	// The RC source waits a few cycles before converting so that sleep can be entered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			hold_r <= 1'b0;
			wait_r <= 4'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					wait_r <= 4'h0;
					if (start) begin
						state_r <= rc_sel ? ST_WAIT : ST_CONV;
						hold_r <= !rc_sel;
					end
				end
				ST_WAIT: begin
					wait_r <= wait_r + 4'h1;
					if (abort) begin
						state_r <= ST_IDLE;
					end else if (wait_r == RC_START_WAIT - 4'h1) begin
						state_r <= ST_CONV;
						hold_r <= 1'b1;
					end
				end
				ST_CONV: begin
					if (load) begin
						state_r <= ST_IDLE;
						hold_r <= 1'b0;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					hold_r <= 1'b0;
				end
			endcase
		end
	end

	// Even half periods 2 to 20 put a trial bit on the DAC, odd ones 3 to 21 keep or drop it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_r <= 5'h00;
			sar_r <= '0;
			decided_r <= '0;
			bit_r <= 4'h0;
			last_bit_r <= 1'b0;
		end else if (start) begin
			step_r <= 5'h00;
			sar_r <= '0;
			decided_r <= '0;
			bit_r <= 4'(RES_W - 1);
			last_bit_r <= 1'b0;
		end else if (conv && half_tick) begin
			step_r <= step_r + 5'h01;
			if (!step_r[0] && step_r >= STEP_FIRST_BIT && step_r < STEP_LAST) begin
				sar_r[bit_r] <= 1'b1;
			end
			if (step_r[0] && step_r > STEP_FIRST_BIT) begin
				sar_r[bit_r] <= cmp_r;
				decided_r[bit_r] <= 1'b1;
				last_bit_r <= cmp_r;
				bit_r <= bit_r - 4'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_high_r <= RST_RESULT;
			res_low_r <= RST_RESULT;
		end else if (load) begin
			{res_high_r, res_low_r} <= sac_format(final_code, justify_r);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ht_cnt_r <= 6'h00;
		end else if (start) begin
			ht_cnt_r <= 6'h00;
		end else if (conv && half_tick) begin
			ht_cnt_r <= ht_cnt_r + 6'h01;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_finish;
		finish;
	endsequence
	sequence s_idle_after;
		!busy && !hold_r;
	endsequence

	property p_finish_flag;
		s_finish |=> (flag_r and s_idle_after);
	endproperty
	a_finish_flag: assert property (p_finish_flag)
		else $error("Completion did not set the flag and end the conversion.");

	property p_flag_sticky;
		flag_r && !flag_clr |=> flag_r;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("Completion flag dropped without a software clear.");

	property p_irq_follow;
		1'b1 |=> irq_r == $past(flag_r && irq_en_r);
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("Interrupt does not follow flag and enable.");

	property p_conv_len;
		s_finish |-> ht_cnt_r == 6'h16;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("Conversion did not span twenty-three half periods.");

	property p_chan_reserved;
		enable_r && chs_r > CHS_PIN_LAST && chs_r < CHS_TEMP |=> chan_r == '0;
	endproperty
	a_chan_reserved: assert property (p_chan_reserved)
		else $error("Reserved channel code connected a source.");

	property p_chan_temp;
		enable_r && chs_r == CHS_TEMP |=> chan_r[4] && $onehot(chan_r);
	endproperty
	a_chan_temp: assert property (p_chan_temp)
		else $error("Temperature channel not connected alone.");

	property p_justify;
		load |=> ($past(justify_r) ? res_high_r[7:2] == 6'h00 : res_low_r[5:0] == 6'h00);
	endproperty
	a_justify: assert property (p_justify)
		else $error("Padding bits of the result are not zero.");

	property p_result_hold;
		!load |=> $stable(res_high_r) && $stable(res_low_r);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("Result changed without a completion or abort.");

	property p_disabled_idle;
		!enable_r |-> !busy;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("Conversion running while the converter is disabled.");

	property p_sleep_abort;
		busy && sleep_in && !rc_sel |=> s_idle_after;
	endproperty
	a_sleep_abort: assert property (p_sleep_abort)
		else $error("Divided-clock conversion survived sleep.");

	property p_div_slowest;
		conv && cks_r == 3'h6 && half_tick |=> !half_tick [*8];
	endproperty
	a_div_slowest: assert property (p_div_slowest)
		else $error("Divide by sixty-four ticked too early.");
endmodule : sac_top
`default_nettype wire

// ===== dv/sac_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_front_model
	import sac_pkg::*;
(
	// Converter side.
	input wire logic [NUM_CHAN-1:0] chan_connect,
	input wire logic [RES_W-1:0] dac_code,
	input wire logic converter_power,
	// Source levels set by the bench.
	input wire logic [NUM_CHAN*RES_W-1:0] levels,
	// Comparator and oscillator.
	output logic cmp_in,
	output logic rc_osc_in
);
	logic junk_r = 1'b0;
	logic [RES_W-1:0] lvl;
	always_comb begin
		lvl = '0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (chan_connect[i]) begin
				lvl = levels[i*RES_W +: RES_W];
			end
		end
	end
	// An open input or an unpowered comparator gives no stable answer.
	always #3 junk_r = ~junk_r;
	assign cmp_in = (converter_power && chan_connect != '0) ? (lvl >= dac_code) : junk_r;
	// The dedicated oscillator runs free, unrelated to the system clock.
	initial begin
		rc_osc_in = 1'b0;
		forever #27.1 rc_osc_in = ~rc_osc_in;
	end
endmodule : sac_front_model
`default_nettype wire

// ===== dv/sar_adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_bench;
	import sac_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep_in = 1'b0, ie = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid, cmp_in, rc_osc, sample_hold, power, irq, wake;
	logic [1:0] bresp, rresp, pref;
	logic [NUM_CHAN-1:0] chan;
	logic [RES_W-1:0] dac;
	logic [NUM_CHAN*RES_W-1:0] levels = '0;
	logic [4:0] chs_tab [NUM_CHAN] = '{5'h00, 5'h01, 5'h02, 5'h03, CHS_TEMP, CHS_DAC, CHS_REFBUF};
	int n_errors = 0, comparisons = 0, cycles = 0, run = 0, last_run = 0;
	sac_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cmp_in(cmp_in), .rc_osc_in(rc_osc), .chan_connect(chan), .sample_hold(sample_hold),
		.dac_code(dac), .positive_reference_select(pref), .converter_power(power),
		.sleep_in(sleep_in), .irq(irq), .wake_req(wake));
	sac_front_model front (.chan_connect(chan), .dac_code(dac), .converter_power(power),
		.levels(levels), .cmp_in(cmp_in), .rc_osc_in(rc_osc));
	initial begin
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (sample_hold === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_run <= run;
			run <= 0;
		end
		if (cycles == 40000) begin
			n_errors++;
			results();
		end
	end
	task automatic results();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask : chk
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axw
	task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axr
	// High byte above low byte, as software should see the pair.
	function automatic logic [15:0] fmt(input logic [9:0] v, input logic right);
		if (right) begin
			return {6'h00, v};
		end
		return {v, 6'h00};
	endfunction : fmt
	task automatic conv(input logic [2:0] cks, input int ci, input logic right,
		input logic [9:0] lv, input logic slp);
		int n, h;
		logic [1:0] r, pr;
		logic [31:0] d;
		logic [15:0] e;
		logic [NUM_CHAN*RES_W-1:0] vl;
		logic done;
		logic [15:0] m;
		vl = (NUM_CHAN*RES_W)'({$urandom(), $urandom(), $urandom()});
		vl[ci*RES_W +: RES_W] = lv;
		levels <= vl;
		pr = 2'($urandom());
		h = 1 << (cks[2] + 2 * cks[1:0]);
		done = !slp || cks[1:0] == CKS_RC_LOW;
		e = fmt(lv, right);
		// Below a half period of eight cycles the filtered comparator lags the trial
		// bit, so only the zero padding of the result is defined there.
		m = (cks[1:0] != CKS_RC_LOW && h < 8) ? (right ? 16'hFC00 : 16'h003F) : 16'hFFFF;
		axw(OFF_CTRL_SECOND, {right, cks, 2'h0, pr}, r);
		axw(OFF_CTRL_FIRST, {1'b0, chs_tab[ci], 2'h1}, r);
		@(posedge aclk);
		chk("chan_connect", 32'(1 << ci), 32'(chan));
		chk("reference", 32'(pr), 32'(pref));
		repeat (20) @(posedge aclk);
		axw(OFF_CTRL_FIRST, {1'b0, chs_tab[ci], 2'h3}, r);
		sleep_in <= slp;
		repeat (12) @(posedge aclk);
		n = 0;
		while (sample_hold === 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk("hold_released", 32'h0, 32'(sample_hold));
		repeat (3) @(posedge aclk);
		if (!slp && cks[1:0] != CKS_RC_LOW) begin
			comparisons++;
			if (last_run < 23 * h || last_run > 23 * h + 3) begin
				$display("MISMATCH duration expected %0d seen %0d", 23 * h, last_run);
				n_errors++;
			end
		end
		chk("irq", 32'(ie && done), 32'(irq));
		chk("wake", 32'(ie && done && slp), 32'(wake));
		chk("power", 32'(!slp || (done && ie)), 32'(power));
		sleep_in <= 1'b0;
		axr(OFF_IRQ_STATUS, d, r);
		chk("done_flag", 32'(done), d);
		axr(OFF_CTRL_FIRST, d, r);
		chk("busy", 32'h0, 32'(d[F_GO]));
		if (done) begin
			axr(OFF_RES_HIGH, d, r);
			chk("result_high", 32'(e[15:8] & m[15:8]), d & 32'(m[15:8]));
			axr(OFF_RES_LOW, d, r);
			chk("result_low", 32'(e[7:0] & m[7:0]), d & 32'(m[7:0]));
			axr(OFF_IRQ_STATUS, d, r);
			chk("flag_held", 32'h1, d);
		end
		axw(OFF_IRQ_CLEAR, 8'h01, r);
		repeat (3) @(posedge aclk);
		chk("irq_cleared", 32'h0, 32'(irq));
	endtask : conv
	initial begin
		logic [31:0] d, h0, l0;
		logic [1:0] r;
		void'($urandom(32'h8E6D4F69));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			axr(5'(a * 4), d, r);
			chk("reset_read", (a == 7) ? 32'h80000000 : 32'h0, {r, d[29:0]});
		end
		axw(5'h1C, 8'hFF, r);
		chk("unmapped_write", 32'(RESP_SLVERR), 32'(r));
		axw(5'h01, 8'hFF, r);
		chk("misaligned_write", 32'(RESP_SLVERR), 32'(r));
		chk("chan_disabled", 32'h0, 32'(chan));
		axw(OFF_CTRL_FIRST, 8'h03, r);
		repeat (4) @(posedge aclk);
		chk("start_with_enable", 32'h0, 32'(sample_hold));
		axw(OFF_CTRL_FIRST, {1'b0, 5'h04, 2'h1}, r);
		@(posedge aclk);
		chk("reserved_channel", 32'h0, 32'(chan));
		for (int k = 0; k < 8; k++) begin
			conv(3'(k), k % 7, 1'(k), (k == 5) ? 10'h000 : (k == 6) ? 10'h3FF : 10'($urandom()), 1'b0);
		end
		ie = 1'b1;
		axw(OFF_IRQ_ENABLE, 8'h01, r);
		for (int k = 0; k < 4; k++) begin
			conv(3'($urandom_range(7)), $urandom_range(6), 1'($urandom()), 10'($urandom()), 1'b0);
		end
		conv(3'h3, $urandom_range(6), 1'b1, 10'($urandom()), 1'b1);
		conv(3'h1, $urandom_range(6), 1'b0, 10'($urandom()), 1'b1);
		axw(OFF_CTRL_SECOND, 8'h60, r);
		axw(OFF_CTRL_FIRST, 8'h03, r);
		repeat (100) @(posedge aclk);
		axw(OFF_CTRL_FIRST, 8'h01, r);
		repeat (3) @(posedge aclk);
		chk("abort_sampling", 32'h0, 32'(sample_hold));
		axr(OFF_IRQ_STATUS, d, r);
		chk("abort_flag", 32'h0, d);
		axr(OFF_RES_HIGH, h0, r);
		axr(OFF_RES_LOW, l0, r);
		axw(OFF_CTRL_FIRST, 8'h00, r);
		axw(OFF_CTRL_FIRST, 8'h01, r);
		axr(OFF_RES_HIGH, d, r);
		chk("hold_high", h0, d);
		axr(OFF_RES_LOW, d, r);
		chk("hold_low", l0, d);
		results();
	end
endmodule : sar_adc_control_bench
`default_nettype wire
